/* rtl/qbp_pkg.sv */
package qbp_pkg;
   // machine cycle is six states of two phases
   localparam int STATES_PER_CYCLE = 6;
   localparam int PHASES_PER_CYCLE = 12;
   localparam logic [3:0] PH_LAST = 4'hB;
   // state1_phase1 is phase index 0, state5 p1/p2 are 8/9
   localparam logic [3:0] PH_STATE1_PHASE1 = 4'h0;
   localparam logic [3:0] PH_STATE1_PHASE2 = 4'h1;
   localparam logic [3:0] PH_STATE5_PHASE1 = 4'h8;
   localparam logic [3:0] PH_STATE5_PHASE2 = 4'h9;
   localparam logic [3:0] PH_STATE6_PHASE2 = 4'hB;
   // phase counter reset and wrap value (one mclk per phase)
   localparam logic [3:0] OSC_DIV_RESET = 4'h0;
   // latches after reset hold all ones
   localparam logic [7:0] LATCH_RESET = 8'hFF;
   localparam int PORT_W = 8;
   localparam int NUM_PORTS = 4;
   // alternate function bit positions
   localparam int P1_TIMER2_COUNT = 0;
   localparam int P1_TIMER2_TRIG = 1;
   localparam int P3_SER_RX = 0;
   localparam int P3_SER_TX = 1;
   localparam int P3_EXT_INT0 = 2;
   localparam int P3_EXT_EXT_INTERRUPT1_INPUT = 3;
   localparam int P3_TIMER0_COUNT = 4;
   localparam int P3_TIMER1_COUNT = 5;
   localparam int P3_WR_STROBE = 6;
   localparam int P3_RD_STROBE = 7;

   // per-pin driver state
   typedef enum logic [2:0] {
      DRV_INPUT_LOW = 3'b000,
      DRV_STEADY_HIGH = 3'b001,
      DRV_FORCED_HIGH = 3'b010,
      DRV_OUTPUT_LOW = 3'b011,
      DRV_FLOAT = 3'b100
   } qbp_drv_e;

   // driver enables of one pin
   typedef struct packed {
      logic low_side_pulldown;
      logic boost_pullup;
      logic weak_pullup;
      logic keeper_pullup;
   } qbp_drv_s;

   // cpu port access request
   typedef struct packed {
      logic wr;        // byte write, taken at state6_phase2
      logic bit_wr;    // bit write (move, clear, set)
      logic rmw;       // read side of read-modify-write
      logic [1:0] port;
      logic [2:0] bit_sel;
      logic bit_val;
      logic [7:0] data;
   } qbp_req_s;

   // timing flags of the machine cycle
   typedef struct packed {
      logic state1_phase1;
      logic state1_phase2;
      logic state5_phase1;
      logic state5_phase2;
      logic state6_phase2;
   } qbp_tick_s;
endpackage

/* rtl/qbp_phase_gen.sv */
module qbp_phase_gen
   import qbp_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // phase enables
   output qbp_tick_s o_tick,
   output logic [3:0] o_phase
);
   logic [3:0] phase_q;
   logic [3:0] phase_d;

   // next phase, wraps after state 6 phase 2
   always_comb begin
      if (phase_q == PH_LAST) begin
         phase_d = OSC_DIV_RESET;
      end else begin
         phase_d = phase_q + 4'h1;
      end
   end

   // phase counter register
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         phase_q <= OSC_DIV_RESET;
      end else begin
         phase_q <= phase_d;
      end
   end

   // decode of the phases the ports care about
   always_comb begin
      o_tick.state1_phase1 = (phase_q == PH_STATE1_PHASE1);
      o_tick.state1_phase2 = (phase_q == PH_STATE1_PHASE2);
      o_tick.state5_phase1 = (phase_q == PH_STATE5_PHASE1);
      o_tick.state5_phase2 = (phase_q == PH_STATE5_PHASE2);
      o_tick.state6_phase2 = (phase_q == PH_STATE6_PHASE2);
   end

   assign o_phase = phase_q;
endmodule

/* rtl/qbp_port_logic.sv */
module qbp_port_logic
   import qbp_pkg::*;
#(
   parameter int W = PORT_W
)
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // cpu port access
   input qbp_req_s i_req,
   output logic [W-1:0] o_rd_data,
   // external bus control from the core
   input wire logic i_external_access_pin,
   input wire logic i_pc_above_rom,
   input wire logic i_ext_cycle,
   input wire logic i_addr16,
   input wire logic [W-1:0] i_bus_lo,
   input wire logic [W-1:0] i_bus_hi,
   input wire logic i_bus_lo_oe,
   // alternate outputs of ports 1 and 3
   input wire logic [W-1:0] i_alt_out_p1,
   input wire logic [W-1:0] i_alt_out_p3,
   // pins: sensed level and per-pin drivers, index port*W+bit
   input wire logic [NUM_PORTS*W-1:0] i_pin,
   output qbp_drv_s [NUM_PORTS*W-1:0] o_drv,
   // alternate inputs, sampled once per machine cycle, then the registered bus mode flag
   output logic [W-1:0] o_alt_in_p1,
   output logic [W-1:0] o_alt_in_p3,
   output logic [W-1:0] o_fall_p1,
   output logic [W-1:0] o_fall_p3,
   output logic o_bus_mode
);
   // one mclk is one phase, so a machine cycle is twelve
   // mclk periods; every slower event below is a one-cycle
   // tick of the phase counter, never a derived clock
   qbp_tick_s tick;
   logic [3:0] phase;

   // machine cycle phase enables
   qbp_phase_gen u_phase (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .o_tick(tick),
      .o_phase(phase)
   );

   // pin synchroniser; also the digital trip point of the keeper
   // the sensed level is two mclk late; harmless, since outside
   // levels are held a whole machine cycle and the keeper only
   // adds current once the pin is already high
   logic [NUM_PORTS*W-1:0] pin_meta_q;
   logic [NUM_PORTS*W-1:0] pin_sync_q;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= i_pin;
         pin_sync_q <= pin_meta_q;
      end
   end

   // latch is what the cpu wrote; buffer is the copy the
   // drivers use, so a write reaches the pin only at the
   // next state one, never mid-cycle
   // port latches and per-pin state
   logic [W-1:0] latch_q [NUM_PORTS];
   logic [W-1:0] latch_d [NUM_PORTS];
   logic [W-1:0] buf_q [NUM_PORTS];     // output buffer copy
   logic [W-1:0] buf_d [NUM_PORTS];
   logic [W-1:0] rise_q [NUM_PORTS];    // zero-to-one pending
   logic [W-1:0] rise_d [NUM_PORTS];
   logic [W-1:0] samp_q [NUM_PORTS];    // state-five sample
   logic [W-1:0] samp_d [NUM_PORTS];
   logic [W-1:0] prev_q [NUM_PORTS];    // previous cycle sample
   logic [W-1:0] prev_d [NUM_PORTS];
   logic bus_q;
   logic bus_d;

   // bit writes start from the latch, not the pins, so a pin
   // held low from outside is not copied back as a zero
   // merge a bit into a byte taken from the latch
   function automatic logic [W-1:0] put_bit(input logic [W-1:0] b,
         input logic [2:0] sel, input logic v);
      logic [W-1:0] r;
      r = b;
      r[sel] = v;
      return r;
   endfunction

   // bus mode when program comes from outside: access pin
   // low, counter past the internal rom, or a data access
   // to external memory in progress
   // bus select logic
   logic bus_sel;
   assign bus_sel = ~i_external_access_pin | i_pc_above_rom | i_ext_cycle;

   // order matters below: the cpu write comes first so that
   // the bus-mode override of port zero wins over it, and the
   // rise clear skips both state-one phases so that state one
   // keeps the capture; everything else holds its value by default
   // one write per machine cycle, taken only at state6_phase2
   // next state of latches, buffers and samples
   always_comb begin
      bus_d = bus_sel;
      for (int p = 0; p < NUM_PORTS; p++) begin
         latch_d[p] = latch_q[p];
         buf_d[p] = buf_q[p];
         rise_d[p] = rise_q[p];
         samp_d[p] = samp_q[p];
         prev_d[p] = prev_q[p];
         if (tick.state6_phase2 && i_req.port == 2'(p)) begin
            if (i_req.bit_wr) begin
               latch_d[p] = put_bit(latch_q[p], i_req.bit_sel,
                  i_req.bit_val);
            end else if (i_req.wr) begin
               latch_d[p] = i_req.data;
            end
         end
         // port zero latch is forced to ones in bus mode
         if (p == 0 && bus_q) begin
            latch_d[p] = LATCH_RESET;
         end
         // buffer captures at phase one only
         if (!phase[0]) begin
            buf_d[p] = latch_q[p];
            if (tick.state1_phase1) begin
               rise_d[p] = latch_q[p] & ~buf_q[p];
            end
         end
         // rise only survives the two state-one phases
         if (!tick.state1_phase2 && !tick.state1_phase1) begin
            // forced high ends after two periods
            rise_d[p] = '0;
         end
         if (tick.state5_phase2) begin
            prev_d[p] = samp_q[p];
            samp_d[p] = pin_sync_q[p*W +: W];
         end
      end
   end

   // reset leaves every quasi pin weak-high with the keeper
   // off until the synchroniser sees the pin high
   // latches reset to ones
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            latch_q[p] <= LATCH_RESET;
            buf_q[p] <= LATCH_RESET;
            rise_q[p] <= '0;
            samp_q[p] <= LATCH_RESET;
            prev_q[p] <= LATCH_RESET;
         end
         bus_q <= 1'b0;
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            latch_q[p] <= latch_d[p];
            buf_q[p] <= buf_d[p];
            rise_q[p] <= rise_d[p];
            samp_q[p] <= samp_d[p];
            prev_q[p] <= prev_d[p];
         end
         bus_q <= bus_d;
      end
   end

   // read is registered to keep the pin sample path short;
   // the cost is one mclk of latency, well inside the
   // machine cycle the cpu spends on the access
   // cpu read data, registered
   logic [W-1:0] rd_q;
   logic [W-1:0] rd_d;

   always_comb begin
      if (i_req.rmw || i_req.bit_wr) begin
         rd_d = latch_q[i_req.port];
      end else begin
         rd_d = samp_q[i_req.port];
      end
   end

   // read data register
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         rd_q <= '0;
      end else begin
         rd_q <= rd_d;
      end
   end

   // read data lands one mclk after the request; the caller
   // holds the request through the state6_phase2 edge
   assign o_rd_data = rd_q;
   // bus select is registered so it never glitches the drivers
   assign o_bus_mode = bus_q;

   // enables are combinational from registers only: buffer,
   // rise and synchronised sense, plus the bus and alternate output inputs, which
   // come from logic on this same clock
   // port zero and port two take bus values only in bus mode;
   // the latches stay untouched apart from port zero's ones
   // driver enables, one generate per pin
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      for (genvar b = 0; b < W; b++) begin : g_bit
         qbp_drv_s drv;
         logic lv;       // level the driver wants
         logic boost;
         logic sensed;
         assign sensed = pin_sync_q[p*W+b];
         always_comb begin
            lv = buf_q[p][b];
            boost = rise_q[p][b];
            if (p == 1) begin
               lv = buf_q[p][b] & i_alt_out_p1[b];
            end
            if (p == 3) begin
               lv = buf_q[p][b] & i_alt_out_p3[b];
            end
            if (p == 0 && bus_q) begin
               lv = i_bus_lo[b];
            end
            if (p == 2 && bus_q && i_addr16) begin
               lv = i_bus_hi[b];
            end
            drv = '0;
            if (p == 0) begin
               // no weak or keeper here: an outside pullup is
               // needed for a high level in port use
               // open drain except bus ones
               drv.low_side_pulldown = ~lv & (~bus_q | i_bus_lo_oe);
               drv.boost_pullup = lv & bus_q & i_bus_lo_oe;
            end else if (p == 2 && bus_q && i_addr16) begin
               // strong both ways so the high address byte
               // settles fast, at the cost of supply current
               // boost drives ones all cycle
               drv.low_side_pulldown = ~lv;
               drv.boost_pullup = lv;
            end else begin
               // four states from level, rise and sense
               drv.low_side_pulldown = ~lv;
               drv.weak_pullup = lv;
               drv.keeper_pullup = lv & sensed;
               // boost on top of weak in forced high
               drv.boost_pullup = lv & boost;
               // keeper is not forced in forced high: it waits for
               // the sensed level, so a pin held low from outside
               // never gets keeper current
            end
         end
         assign o_drv[p*W+b] = drv;
      end
   end

   // timer, interrupt and serial inputs share the state-five
   // sample; a latch at zero pulls the pin low, so the gate
   // only hides what the pulldown itself would show
   // alternate inputs, gated by latch one
   always_comb begin
      o_alt_in_p1 = samp_q[1] & latch_q[1];
      o_alt_in_p3 = samp_q[3] & latch_q[3];
      // falling edge seen across two state-five samples
      o_fall_p1 = prev_q[1] & ~samp_q[1] & latch_q[1];
      o_fall_p3 = prev_q[3] & ~samp_q[3] & latch_q[3];
   end
endmodule

/* testbench/qbp_port_logic_chk.sv */
module qbp_chk
   import qbp_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // watched ports
   input wire logic i_external_access_pin,
   input wire logic i_pc_above_rom,
   input wire logic i_ext_cycle,
   input wire logic [31:0] i_pin,
   input wire qbp_drv_s [31:0] o_drv,
   input wire logic [7:0] o_alt_in_p3,
   input wire logic [7:0] o_fall_p3,
   input wire logic o_bus_mode
);
   logic [31:0] pd, bo, wk, kp; // enables split per pin
   logic [3:0] ph_q, ph_d; // phase within the machine cycle
   // unpack driver structs
   always_comb begin
      for (int k = 0; k < 32; k++) begin
         {pd[k], bo[k], wk[k], kp[k]} = o_drv[k];
      end
   end
   // phase count, zero after reset like the design
   always_comb begin
      ph_d = (ph_q == PH_LAST) ? 4'h0 : ph_q + 4'h1;
   end
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ph_q <= 4'h0;
      end else begin
         ph_q <= ph_d;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   a_drv_excl: assert property ((pd & (bo | wk | kp)) == 32'h0)
      else $error("pulldown on with a pullup");
   a_latch_drive: assert property ((pd[15:8] ^ wk[15:8]) == 8'hFF)
      else $error("pulldown and weak pullup not exclusive");
   // the synchroniser lag is covered by four low samples
   a_keeper_sense: assert property ((kp & ~(i_pin | $past(i_pin)
      | $past(i_pin, 2) | $past(i_pin, 3))) == 32'h0)
      else $error("keeper on with pin low");
   a_p0_nopull: assert property ((wk[7:0] | kp[7:0]) == 8'h0)
      else $error("port zero weak or keeper on");
   a_p0_float: assert property (!o_bus_mode && !$past(o_bus_mode)
      && !$past(o_bus_mode, 13) |-> bo[7:0] == 8'h0)
      else $error("port zero pullup outside bus mode");
   a_boost_two: assert property ($rose(bo[8]) |=> bo[8] ##1 !bo[8])
      else $error("boost not two phases");
   a_pin_phase: assert property (($changed(pd[8]) || $rose(bo[8]))
      |-> ph_q < 4'h3)
      else $error("driver change outside state one");
   a_bus_sel: assert property (o_bus_mode
      == $past(!i_external_access_pin | i_pc_above_rom | i_ext_cycle))
      else $error("bus select wrong");
   a_alt_hold: assert property ($changed(o_alt_in_p3)
      |=> $stable(o_alt_in_p3) [*8])
      else $error("alternate input sampled twice a cycle");
   a_fall_low: assert property ((o_fall_p3 & o_alt_in_p3) == 8'h0)
      else $error("falling edge with high sample");
   c_boost: cover property ($rose(bo[8]));
   c_bus: cover property ($rose(o_bus_mode));
   c_fall: cover property (o_fall_p3 != 8'h0);
endmodule

bind qbp_port_logic qbp_chk u_qbp_chk (.i_mclk, .i_rst,
   .i_external_access_pin, .i_pc_above_rom, .i_ext_cycle, .i_pin,
   .o_drv, .o_alt_in_p3, .o_fall_p3, .o_bus_mode);

/* testbench/qbp_pin_model.sv */
module qbp_pin_model
   import qbp_pkg::*;
(
   // clock
   input wire logic i_mclk,
   // block drivers and outside drive
   input wire qbp_drv_s [31:0] i_drv,
   input wire logic [31:0] i_ext_oe,
   input wire logic [31:0] i_ext_val,
   // sensed level
   output logic [31:0] o_pin
);
   logic [31:0] flt_q = 32'h0; // undriven pins toggle, never hold
   always_ff @(posedge i_mclk) begin
      flt_q <= ~flt_q;
   end
   // pulldown wins, then outside, then pullups
   always_comb begin
      for (int k = 0; k < 32; k++) begin
         o_pin[k] = i_drv[k].low_side_pulldown ? 1'b0 : i_ext_oe[k] ?
            i_ext_val[k] : (i_drv[k] != 4'h0) ? 1'b1 : flt_q[k];
      end
   end
endmodule

/* testbench/qbp_port_logic_bench.sv */
module qbp_port_logic_bench
   import qbp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   qbp_req_s req = 17'h00000;
   logic ea = 1'b1, pc = 1'b0, ext = 1'b0, a16 = 1'b0, lo_oe = 1'b0;
   logic [7:0] blo = 8'h00, bhi = 8'h00, alt3 = 8'hFF, prev3 = 8'hFF;
   logic [7:0] alt1 = 8'hFF, prev1 = 8'hFF, f1; // port one side
   qbp_req_s req_n; // next random write
   logic [31:0] oe = 32'h0, val = 32'h0, pin, seed = 32'h5DB819E3;
   logic [31:0] pd, bo, wk;
   qbp_drv_s [31:0] drv;
   logic [7:0] rd, ai1, ai3, f3, lat [4];
   logic [1:0] p;
   logic bm;
   logic [3:0] ph = 4'h0; // bench copy of the phase
   int err_count = 0, n_checks = 0;
   initial begin
      forever #20 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk or posedge i_rst) begin
      ph <= (i_rst || ph == PH_LAST) ? 4'h0 : ph + 4'h1;
   end
   always_comb begin
      for (int k = 0; k < 32; k++) begin
         {pd[k], bo[k], wk[k]} = drv[k][3:1];
      end
   end
   qbp_port_logic u_qbp_port_logic (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_req(req), .o_rd_data(rd), .i_external_access_pin(ea),
      .i_pc_above_rom(pc), .i_ext_cycle(ext), .i_addr16(a16),
      .i_bus_lo(blo), .i_bus_hi(bhi), .i_bus_lo_oe(lo_oe),
      .i_alt_out_p1(alt1), .i_alt_out_p3(alt3), .i_pin(pin), .o_drv(drv),
      .o_alt_in_p1(ai1), .o_alt_in_p3(ai3), .o_fall_p1(f1), .o_fall_p3(f3),
      .o_bus_mode(bm));
   qbp_pin_model u_qbp_pin_model (.i_mclk(i_mclk), .i_drv(drv),
      .i_ext_oe(oe), .i_ext_val(val), .o_pin(pin));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // level the block wants: latch gated by the alternate output
   function automatic logic [7:0] drv_on(input int q);
      return lat[q] & ((q == 3) ? alt3 : (q == 1) ? alt1 : 8'hFF);
   endfunction
   // pin level seen from latch, alternate output and outside drive
   function automatic logic [7:0] exp_pin(input int q);
      return drv_on(q) & (~oe[q*8+:8] | val[q*8+:8]);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // requests are taken only at the phase eleven edge
   task automatic issue(input qbp_req_s r);
      while (ph != PH_LAST) @(negedge i_mclk);
      req = r;
      @(negedge i_mclk);
      req = 17'h00000;
   endtask
   task automatic boost_cnt(input int n);
      int c;
      c = 0;
      repeat (12) begin
         c += bo[8];
         @(negedge i_mclk);
      end
      chk(8'(c), 8'(n));
   endtask
   initial begin
      #(40 * 12000);
      err_count++;
      tally_and_finish();
   end
   initial begin
      lat = '{default: 8'hFF};
      repeat (2) @(negedge i_mclk);
      i_rst = 1'b0;
      for (int q = 0; q < 4; q++) begin
         issue({3'b001, 2'(q), 12'h000});
         chk(rd, 8'hFF);
      end
      chk(wk[15:8], 8'hFF);
      issue({3'b100, 2'h1, 12'h000});
      issue({3'b100, 2'h1, 12'h0FF});
      boost_cnt(2);
      issue({3'b100, 2'h1, 12'h0FF});
      boost_cnt(0);
      repeat (40) begin
         seed = lfsr(seed);
         p = seed[1:0];
         if (seed[2]) begin
            req_n = {3'b010, p, seed[5:3], seed[6], 8'h00};
            lat[p][seed[5:3]] = seed[6];
         end else begin
            req_n = {3'b100, p, 4'h0, seed[15:8]};
            lat[p] = seed[15:8];
         end
         // let go of pins whose latch drops, at the negedge just before the write edge
         while (ph != PH_LAST) @(negedge i_mclk);
         oe = oe & {lat[3], lat[2], lat[1], lat[0]};
         issue(req_n);
         alt3 = seed[23:16] | seed[31:24];
         alt1 = seed[7:0] | seed[23:16];
         seed = lfsr(seed);
         val = seed;
         // port zero floats on a one, so the outside drives every port zero pin whose latch is one
         oe = (lfsr(seed) | 32'h000000FF)
            & {lat[3] & alt3, lat[2], lat[1] & alt1, lat[0]};
         while (ph != PH_LAST) @(negedge i_mclk);
         for (int q = 1; q < 4; q++) begin
            chk(pd[q*8+:8], ~drv_on(q));
         end
         chk(wk[15:8], drv_on(1));
         chk(wk[23:16], lat[2]);
         chk(ai1, exp_pin(1));
         chk(ai3, exp_pin(3));
         chk(f1, prev1 & ~exp_pin(1) & lat[1]);
         chk(f3, prev3 & ~exp_pin(3) & lat[3]);
         prev1 = exp_pin(1);
         prev3 = exp_pin(3);
         issue({3'b001, p, 12'h000});
         chk(rd, lat[p]);
         issue({3'b000, p, 12'h000});
         chk(rd, exp_pin(p));
      end
      for (int i = 0; i < 3; i++) begin
         ea = (i != 0);
         pc = (i == 1);
         ext = (i == 2);
         repeat (2) @(negedge i_mclk);
         chk({7'h00, bm}, 8'h01);
      end
      a16 = 1'b1;
      lo_oe = 1'b1;
      oe = 32'h0; // the block owns ports zero and two now
      bhi = seed[7:0];
      blo = seed[15:8];
      repeat (12) @(negedge i_mclk);
      chk(bo[23:16], bhi);
      chk(bo[7:0], blo);
      issue({3'b001, 2'h0, 12'h000});
      chk(rd, 8'hFF);
      issue({3'b001, 2'h2, 12'h000});
      chk(rd, lat[2]);
      tally_and_finish();
   end
endmodule
